// file: rtl/lvdrc_consts.vh
// Offsets, field positions, reset values and timing counts of the supply supervisor
`ifndef LVDRC_CONSTS_VH
`define LVDRC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LVDRC_CTRL_OFS      12'h000
`define LVDRC_STAT_OFS      12'h004

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define LVDRC_RISE_EN_BIT   0
`define LVDRC_FALL_EN_BIT   1
`define LVDRC_LEVEL_SEL_BIT 3
`define LVDRC_CTRL_ONES     8'hF4
`define LVDRC_LEVEL_SEL_RST 1'b1
`define LVDRC_FALL_EN_RST   1'b0
`define LVDRC_RISE_EN_RST   1'b0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define LVDRC_RISE_FLAG_BIT 0
`define LVDRC_FALL_FLAG_BIT 1
`define LVDRC_STAT_ONES     8'hFC
`define LVDRC_FLAG_RST      1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LVDRC_CLK_NS        4
`define LVDRC_FILT_NS       100
`define LVDRC_FILT_CYC      ((`LVDRC_FILT_NS + `LVDRC_CLK_NS - 1) / `LVDRC_CLK_NS)
`define LVDRC_RELEASE_CYC   131072

`endif

// file: rtl/lvdrc_sync.v
// Two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/100ps

module lvdrc_sync #(
    parameter WIDTH = 1
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             pclk_en,
    input  wire [WIDTH-1:0] async_in,
    input  wire [WIDTH-1:0] reset_val,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else if (pclk_en) begin
            meta_r   <= async_in ^ reset_val;
            sync_out <= meta_r;
        end
    end

endmodule // lvdrc_sync

// file: rtl/lvdrc_top.v
// Supply supervisor: reset sequencing, low-voltage reset and interrupts
`timescale 1ns/100ps
`include "lvdrc_consts.vh"

module lvdrc_top #(
    parameter RELEASE_CYCLES = `LVDRC_RELEASE_CYC,
    parameter CNT_W          = 18,
    parameter FILT_W         = 5
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        pclk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        external_reset_n,
    input  wire        below_high_reset_level,
    input  wire        below_low_reset_level,
    input  wire        below_fall_level,
    input  wire        above_rise_level,
    output wire        internal_reset_n,
    output wire        low_voltage_reset_n,
    output wire        low_voltage_irq_n,
    output wire        external_interrupt_zero,
    output wire        prescaler_overflow
);

    // ----------------------------------------------------------------
    // Constants and helpers
    // ----------------------------------------------------------------
    localparam [1:0] ST_HOLD  = 2'b00;
    localparam [1:0] ST_COUNT = 2'b01;
    localparam [1:0] ST_RUN   = 2'b10;

    localparam integer      FILT_CYC = `LVDRC_FILT_CYC;
    localparam [FILT_W-1:0] FILT_MAX = FILT_CYC[FILT_W-1:0];
    localparam [CNT_W-1:0]  CNT_LAST = RELEASE_CYCLES[CNT_W-1:0] - 1'b1;

    // Rising edge of a synchronised level
    function edge_up;
        input cur;
        input prev;
        begin
            edge_up = cur & ~prev;
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    wire [4:0]        sync_w;
    wire              ext_sync;
    wire              hi_low;
    wire              lo_low;
    wire              fall_low;
    wire              rise_high;
    reg               ext_filt_r;
    reg  [FILT_W-1:0] filt_cnt_r;
    reg  [1:0]        state_r;
    reg  [1:0]        state_nxt;
    reg  [CNT_W-1:0]  pre_cnt_r;
    reg               irst_n_r;
    reg               ovf_r;
    reg               por_done_r;
    reg               lv_reset_r;
    reg               lv_reset_nxt;
    reg               level_sel_r;
    reg               fall_en_r;
    reg               rise_en_r;
    reg               fall_flag_r;
    reg               rise_flag_r;
    reg               fall_arm_r;
    reg               rise_arm_r;
    reg               fall_prev_r;
    reg               rise_prev_r;
    reg               below_seen_r;
    reg               irq_n_r;
    reg               external_interrupt_zero_r;
    reg               rd_ok_r;
    wire              below_sel;
    wire              fall_evt;
    wire              rise_evt;
    wire              rise_ok;
    wire              lv_enter;
    wire              acc;
    wire              hit_ctrl;
    wire              hit_stat;
    wire              wr_ctrl;
    wire              wr_stat;
    wire              rd_stat;
    wire [7:0]        ctrl_val;
    wire [7:0]        stat_val;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Reset pin reads as low after reset since both synchroniser flops clear to zero; the inversion mask is zero
    lvdrc_sync #(
        .WIDTH     (5)
    ) u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pclk_en   (pclk_en),
        .async_in  ({external_reset_n, below_high_reset_level,
                     below_low_reset_level, below_fall_level,
                     above_rise_level}),
        .reset_val (5'h00),
        .sync_out  (sync_w)
    );

    assign ext_sync  = sync_w[4];
    assign hi_low    = sync_w[3];
    assign lo_low    = sync_w[2];
    assign fall_low  = sync_w[1];
    assign rise_high = sync_w[0];

    // ----------------------------------------------------------------
    // External reset noise filter
    // ----------------------------------------------------------------
    // Level follows the pin only after it stays put for the filter time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_filt_r <= 1'b0;
            filt_cnt_r <= {FILT_W{1'b0}};
        end else if (pclk_en) begin
            if (ext_sync == ext_filt_r) begin
                filt_cnt_r <= {FILT_W{1'b0}};
            end else if (filt_cnt_r == FILT_MAX - 1'b1) begin
                ext_filt_r <= ext_sync;
                filt_cnt_r <= {FILT_W{1'b0}};
            end else begin
                filt_cnt_r <= filt_cnt_r + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Reset sequencer
    // ----------------------------------------------------------------
    // Low-voltage reset compares against the selected level
    assign below_sel = level_sel_r ? hi_low : lo_low;
    assign lv_enter  = por_done_r & below_sel;

    // Next state of the sequencer
    always @* begin
        state_nxt    = state_r;
        lv_reset_nxt = lv_reset_r;
        case (state_r)
            ST_HOLD: begin
                if (!lv_reset_r && ext_filt_r) begin
                    state_nxt = ST_COUNT;
                end else if (lv_reset_r && ext_filt_r && !below_sel) begin
                    state_nxt    = ST_COUNT;
                    lv_reset_nxt = 1'b0;
                end
            end
            ST_COUNT: begin
                if (lv_enter) begin
                    state_nxt    = ST_HOLD;
                    lv_reset_nxt = 1'b1;
                end else if (pre_cnt_r == CNT_LAST) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (lv_enter) begin
                    state_nxt    = ST_HOLD;
                    lv_reset_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
        if (!ext_filt_r) begin
            state_nxt    = ST_HOLD;
            lv_reset_nxt = 1'b0;
        end
    end

    // Prescaler, overflow pulse and internal reset level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= ST_HOLD;
            lv_reset_r <= 1'b0;
            pre_cnt_r  <= {CNT_W{1'b0}};
            irst_n_r   <= 1'b0;
            ovf_r      <= 1'b0;
            por_done_r <= 1'b0;
        end else if (pclk_en) begin
            state_r    <= state_nxt;
            lv_reset_r <= lv_reset_nxt;
            ovf_r      <= 1'b0;
            if (state_r == ST_COUNT && state_nxt == ST_COUNT) begin
                pre_cnt_r <= pre_cnt_r + 1'b1;
            end else begin
                pre_cnt_r <= {CNT_W{1'b0}};
            end
            if (state_r == ST_COUNT && state_nxt == ST_RUN) begin
                ovf_r      <= 1'b1;
                irst_n_r   <= 1'b1;
                por_done_r <= 1'b1;
            end else if (state_nxt == ST_HOLD) begin
                irst_n_r <= 1'b0;
            end
            if (!ext_filt_r) begin
                por_done_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Voltage-detect interrupt events
    // ----------------------------------------------------------------
    assign fall_evt = edge_up(fall_low, fall_prev_r) & por_done_r;
    assign rise_evt = edge_up(rise_high, rise_prev_r);
    assign rise_ok  = rise_evt & below_seen_r & ~lo_low;

    // Track a fall that has not yet reached the lower reset level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_prev_r  <= 1'b0;
            rise_prev_r  <= 1'b0;
            below_seen_r <= 1'b0;
            irq_n_r      <= 1'b1;
            external_interrupt_zero_r       <= 1'b0;
        end else if (pclk_en) begin
            fall_prev_r <= fall_low;
            rise_prev_r <= rise_high;
            external_interrupt_zero_r      <= 1'b0;
            if (lo_low || lv_reset_r) begin
                below_seen_r <= 1'b0;
            end else if (fall_evt) begin
                below_seen_r <= 1'b1;
            end else if (rise_ok) begin
                below_seen_r <= 1'b0;
            end
            if (fall_evt) begin
                irq_n_r <= 1'b0;
                external_interrupt_zero_r  <= fall_en_r;
            end else if (rise_ok) begin
                irq_n_r <= 1'b1;
                external_interrupt_zero_r  <= rise_en_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign acc      = psel & penable & pready;
    assign hit_ctrl = (paddr == `LVDRC_CTRL_OFS);
    assign hit_stat = (paddr == `LVDRC_STAT_OFS);
    assign wr_ctrl  = acc & pwrite & hit_ctrl;
    assign wr_stat  = acc & pwrite & hit_stat;
    assign rd_stat  = acc & ~pwrite & hit_stat;
    assign pready   = pclk_en & (pwrite | rd_ok_r);
    assign pslverr  = psel & penable & ~(hit_ctrl | hit_stat);

    // Register images with reserved bits reading one
    assign ctrl_val = `LVDRC_CTRL_ONES
                    | ({7'h00, level_sel_r} << `LVDRC_LEVEL_SEL_BIT)
                    | ({7'h00, fall_en_r} << `LVDRC_FALL_EN_BIT)
                    | ({7'h00, rise_en_r} << `LVDRC_RISE_EN_BIT);
    assign stat_val = `LVDRC_STAT_ONES
                    | ({7'h00, fall_flag_r} << `LVDRC_FALL_FLAG_BIT)
                    | ({7'h00, rise_flag_r} << `LVDRC_RISE_FLAG_BIT);

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    // Level select forced high by a low-voltage reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_sel_r <= `LVDRC_LEVEL_SEL_RST;
            fall_en_r   <= `LVDRC_FALL_EN_RST;
            rise_en_r   <= `LVDRC_RISE_EN_RST;
        end else if (pclk_en) begin
            if (lv_reset_r) begin
                level_sel_r <= `LVDRC_LEVEL_SEL_RST;
            end else if (wr_ctrl) begin
                level_sel_r <= pwdata[`LVDRC_LEVEL_SEL_BIT];
            end
            if (wr_ctrl) begin
                fall_en_r <= pwdata[`LVDRC_FALL_EN_BIT];
                rise_en_r <= pwdata[`LVDRC_RISE_EN_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Status register
    // ----------------------------------------------------------------
    // Sticky flags; a read of one arms the clear, a new event beats it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_flag_r <= `LVDRC_FLAG_RST;
            rise_flag_r <= `LVDRC_FLAG_RST;
            fall_arm_r  <= 1'b0;
            rise_arm_r  <= 1'b0;
        end else if (pclk_en) begin
            if (lv_reset_r) begin
                fall_flag_r <= `LVDRC_FLAG_RST;
                fall_arm_r  <= 1'b0;
            end else if (fall_evt) begin
                fall_flag_r <= 1'b1;
            end else if (wr_stat && fall_arm_r &&
                         !pwdata[`LVDRC_FALL_FLAG_BIT]) begin
                fall_flag_r <= 1'b0;
            end
            if (lv_reset_r) begin
                rise_flag_r <= `LVDRC_FLAG_RST;
                rise_arm_r  <= 1'b0;
            end else if (rise_ok && rise_en_r) begin
                rise_flag_r <= 1'b1;
            end else if (wr_stat && rise_arm_r &&
                         !pwdata[`LVDRC_RISE_FLAG_BIT]) begin
                rise_flag_r <= 1'b0;
            end
            if (!lv_reset_r) begin
                if (rd_stat) begin
                    fall_arm_r <= prdata[`LVDRC_FALL_FLAG_BIT];
                    rise_arm_r <= prdata[`LVDRC_RISE_FLAG_BIT];
                end else if (wr_stat) begin
                    fall_arm_r <= 1'b0;
                    rise_arm_r <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Captured before the access edge; ready waits until a capture is done
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            rd_ok_r <= 1'b0;
        end else if (pclk_en) begin
            if (acc) begin
                rd_ok_r <= 1'b0;
            end else if (psel && !pwrite) begin
                rd_ok_r <= 1'b1;
                if (hit_ctrl) begin
                    prdata <= {24'h000000, ctrl_val};
                end else if (hit_stat) begin
                    prdata <= {24'h000000, stat_val};
                end else begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign internal_reset_n        = irst_n_r;
    assign low_voltage_reset_n     = ~lv_reset_r;
    assign low_voltage_irq_n       = irq_n_r;
    assign external_interrupt_zero = external_interrupt_zero_r;
    assign prescaler_overflow      = ovf_r;

endmodule // lvdrc_top

// file: bench/lvdrc_top_assertions.sv
// Port checker for the supply supervisor
`timescale 1ns/100ps
module lvdrc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic external_reset_n,
    input wire logic below_low_reset_level,
    input wire logic below_fall_level,
    input wire logic above_rise_level,
    input wire logic internal_reset_n,
    input wire logic low_voltage_reset_n,
    input wire logic low_voltage_irq_n,
    input wire logic external_interrupt_zero,
    input wire logic prescaler_overflow
);
    logic       por_seen_r;
    logic [5:0] ext_low_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // First release seen, pin low time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_seen_r <= 1'h0;
            ext_low_r  <= 6'h00;
        end else begin
            if (prescaler_overflow) begin
                por_seen_r <= 1'h1;
            end
            if (external_reset_n) begin
                ext_low_r <= 6'h00;
            end else if (ext_low_r != 6'h3F) begin
                ext_low_r <= ext_low_r + 6'h01;
            end
        end
    end
    ovf_release_a: assert property (prescaler_overflow |->
        internal_reset_n && !$past(internal_reset_n))
        else $error("overflow not tied to reset release");
    ovf_pulse_a: assert property (prescaler_overflow |=> !prescaler_overflow)
        else $error("overflow longer than one cycle");
    irq_pulse_a: assert property (external_interrupt_zero |=> !external_interrupt_zero)
        else $error("interrupt request longer than one cycle");
    lvr_holds_a: assert property (!low_voltage_reset_n |-> !internal_reset_n)
        else $error("chip out of reset during low voltage");
    ext_hold_a: assert property (ext_low_r >= 6'h20 |-> !internal_reset_n)
        else $error("chip out of reset with pin low");
    lvr_armed_a: assert property (!por_seen_r |-> low_voltage_reset_n)
        else $error("low voltage reset before first release");
    lvr_enter_a: assert property ((por_seen_r && below_low_reset_level) [*5] |->
        !low_voltage_reset_n)
        else $error("no low voltage reset below lower level");
    fall_sync_a: assert property ($fell(low_voltage_irq_n) |->
        $past(below_fall_level, 2) || $past(below_fall_level, 3))
        else $error("irq line fell without synced fall");
    rise_sync_a: assert property ($rose(low_voltage_irq_n) |->
        !$past(internal_reset_n) || $past(above_rise_level, 2) || $past(above_rise_level, 3))
        else $error("irq line rose without synced rise");
    cover property (prescaler_overflow);
    cover property (external_interrupt_zero && !low_voltage_irq_n);
    cover property ($fell(low_voltage_reset_n));
endmodule // lvdrc_checker

bind lvdrc_top lvdrc_checker u_chk (
    .pclk(pclk), .presetn(presetn), .external_reset_n(external_reset_n),
    .below_low_reset_level(below_low_reset_level), .below_fall_level(below_fall_level),
    .above_rise_level(above_rise_level), .internal_reset_n(internal_reset_n),
    .low_voltage_reset_n(low_voltage_reset_n), .low_voltage_irq_n(low_voltage_irq_n),
    .external_interrupt_zero(external_interrupt_zero), .prescaler_overflow(prescaler_overflow)
);

// file: bench/lvdrc_supply_model.sv
// Model of the supply comparators and the reset pin
`timescale 1ns/100ps
module lvdrc_supply_model #(
    parameter int LOW_MV  = 2300,
    parameter int HIGH_MV = 3600,
    parameter int FALL_MV = 3700,
    parameter int RISE_MV = 4000
) (
    input  wire logic [15:0] supply_mv,
    input  wire logic        pclk,
    input  wire logic        pin_low,
    output logic             external_reset_n       = 1'h1,
    output logic             below_high_reset_level = 1'h0,
    output logic             below_low_reset_level  = 1'h0,
    output logic             below_fall_level       = 1'h0,
    output logic             above_rise_level       = 1'h1
);
    // Comparators change just after an edge; pin pulses pass unfiltered
    always @(posedge pclk) begin
        external_reset_n       <= !pin_low;
        below_high_reset_level <= supply_mv < HIGH_MV;
        below_low_reset_level  <= supply_mv < LOW_MV;
        below_fall_level       <= supply_mv < FALL_MV;
        above_rise_level       <= supply_mv > RISE_MV;
    end
endmodule // lvdrc_supply_model

// file: bench/lvdrc_tb.sv
// Self-checking bench for the supply supervisor
`timescale 1ns/100ps
module tb;
    localparam int RC = 16;
    logic        pclk = 1'h0, presetn = 1'h0, pclk_en = 1'h1, pin_low = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h45;
    logic [15:0] supply_mv = 16'h1388;
    logic [32:0] rd_q[$];
    wire         pready, pslverr, ext_n, b_hi, b_lo, b_fall, a_rise;
    wire         internal_reset_n, low_voltage_reset_n, low_voltage_irq_n;
    wire         external_interrupt_zero, prescaler_overflow;
    int          errors = 0, check_count = 0, cyc = 0, n = 0;
    logic        bad;

    lvdrc_top #(.RELEASE_CYCLES(RC)) uut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_reset_n(ext_n),
        .below_high_reset_level(b_hi), .below_low_reset_level(b_lo),
        .below_fall_level(b_fall), .above_rise_level(a_rise),
        .internal_reset_n(internal_reset_n), .low_voltage_reset_n(low_voltage_reset_n),
        .low_voltage_irq_n(low_voltage_irq_n), .external_interrupt_zero(external_interrupt_zero),
        .prescaler_overflow(prescaler_overflow));
    lvdrc_supply_model u_sup (.supply_mv(supply_mv), .pclk(pclk), .pin_low(pin_low),
        .external_reset_n(ext_n), .below_high_reset_level(b_hi), .below_low_reset_level(b_lo),
        .below_fall_level(b_fall), .above_rise_level(a_rise));

    initial forever #2 pclk = ~pclk;

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Next xorshift value
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // One APB transfer; reads note their expected {pslverr, prdata}
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        @(posedge pclk);
        if (!w) rd_q.push_back(e);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    // Cycles until the release pulse must fall in [lo, hi]
    task automatic wait_ovf(input int lo, input int hi);
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (prescaler_overflow !== 1'h1 && k < 400);
        check("release_time", {32'h0, k >= lo && k <= hi}, 33'h1);
        check("internal_reset_n", {32'h0, internal_reset_n}, 33'h1);
    endtask

    // Interrupt request seen within ten cycles or not
    task automatic watch_irq(input logic exp);
        logic s;
        s = 1'h0;
        repeat (10) begin
            @(posedge pclk);
            if (external_interrupt_zero === 1'h1) s = 1'h1;
        end
        check("irq_request", {32'h0, s}, {32'h0, exp});
    endtask

    // Read results compared against oldest note
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable && pready && !pwrite) begin
            check("read", {pslverr, prdata}, rd_q.pop_front());
        end
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        wait_ovf(RC, RC + 40);
        apb(1'h0, 12'h000, 32'h0, 33'hFC);
        apb(1'h0, 12'h004, 32'h0, 33'hFC);
        apb(1'h0, 12'h008, 32'h0, 33'h1_0000_0000);
        seed = xs(seed);
        apb(1'h1, 12'h000, seed, 33'h0);
        apb(1'h0, 12'h000, 32'h0, {25'h0, 8'hF4 | (seed[7:0] & 8'h0B)});
        apb(1'h1, 12'h004, seed, 33'h0);
        apb(1'h0, 12'h004, 32'h0, 33'hFC);
        $display("register test done");
        apb(1'h1, 12'h000, 32'h03, 33'h0);
        supply_mv <= 16'h0E42;
        watch_irq(1'h1);
        check("irq_line", {32'h0, low_voltage_irq_n}, 33'h0);
        supply_mv <= 16'h1004;
        watch_irq(1'h1);
        check("irq_line", {32'h0, low_voltage_irq_n}, 33'h1);
        apb(1'h0, 12'h004, 32'h0, 33'hFF);
        apb(1'h1, 12'h004, 32'hFF, 33'h0);
        apb(1'h1, 12'h004, 32'h00, 33'h0);
        apb(1'h0, 12'h004, 32'h0, 33'hFF);
        apb(1'h1, 12'h004, 32'h00, 33'h0);
        apb(1'h0, 12'h004, 32'h0, 33'hFC);
        apb(1'h1, 12'h000, 32'h02, 33'h0);
        supply_mv <= 16'h0E42;
        watch_irq(1'h1);
        supply_mv <= 16'h1004;
        watch_irq(1'h0);
        apb(1'h0, 12'h004, 32'h0, 33'hFE);
        apb(1'h1, 12'h004, 32'h00, 33'h0);
        apb(1'h1, 12'h000, 32'h03, 33'h0);
        supply_mv <= 16'h0ED8;
        repeat (6) @(posedge pclk);
        supply_mv <= 16'h1004;
        watch_irq(1'h0);
        apb(1'h0, 12'h004, 32'h0, 33'hFC);
        $display("interrupt test done");
        for (int i = 0; i < 2; i++) begin
            apb(1'h1, 12'h000, i ? 32'h08 : 32'h03, 33'h0);
            supply_mv <= 16'h0DAC;
            repeat (10) @(posedge pclk);
            check("lv_reset_n", {32'h0, low_voltage_reset_n}, i ? 33'h0 : 33'h1);
            supply_mv <= 16'h07D0;
            repeat (10) @(posedge pclk);
            check("lv_reset_n", {32'h0, low_voltage_reset_n}, 33'h0);
            check("internal_reset_n", {32'h0, internal_reset_n}, 33'h0);
            supply_mv <= 16'h1388;
            wait_ovf(RC, RC + 8);
            apb(1'h0, 12'h000, 32'h0, i ? 33'hFC : 33'hFF);
            apb(1'h0, 12'h004, 32'h0, 33'hFC);
        end
        $display("low voltage reset test done");
        seed = xs(seed);
        n = 1 + seed[3:0];
        bad = 1'h0;
        for (int k = 0; k < 50; k++) begin
            pin_low <= k < n;
            @(posedge pclk);
            if (internal_reset_n !== 1'h1) bad = 1'h1;
        end
        check("short_pulse", {32'h0, bad}, 33'h0);
        pin_low <= 1'h1;
        repeat (40) @(posedge pclk);
        check("internal_reset_n", {32'h0, internal_reset_n}, 33'h0);
        pin_low <= 1'h0;
        wait_ovf(RC + 20, RC + 40);
        $display("reset pin test done");
        fork
            apb(1'h0, 12'h008, 32'h0, 33'h1_0000_0000);
            begin
                @(posedge pclk);
                pclk_en <= 1'h0;
                repeat (4) @(posedge pclk);
                pclk_en <= 1'h1;
            end
        join
        $display("clock enable test done");
        give_verdict();
    end
endmodule // tb
